/* hw/fecb_pkg.sv */
// constants for the channel A coefficient bank (first five taps)
// assumes byte-addressed serial control port with 8-bit data
package fecb_pkg;
    // ******************************************************
    // register byte addresses
    // ******************************************************
    localparam logic [14:0] fecb_tap0_addr    = 15'h0418;
    localparam logic [14:0] fecb_tap1_addr    = 15'h041a;
    localparam logic [14:0] fecb_tap2_addr    = 15'h041c;
    localparam logic [14:0] fecb_tap3_addr    = 15'h041e;
    localparam logic [14:0] fecb_center_addr  = 15'h0420;
    // ******************************************************
    // field layout and reset values
    // ******************************************************
    localparam int          fecb_side_width   = 12;
    localparam int          fecb_side_bytes   = 2;
    localparam int          fecb_center_width = 18;
    localparam int          fecb_center_bytes = 3;
    localparam int          fecb_side_taps    = 4;
    localparam logic [23:0] fecb_reg_reset    = 24'h000000;
    // ******************************************************
    // filter mode encodings
    // ******************************************************
    localparam logic [1:0]  fecb_mode_bypass  = 2'h0;
    localparam logic [1:0]  fecb_mode_run     = 2'h2;
endpackage

/* hw/fecb_coef_reg.sv */
// one coefficient register of several bytes, byte writable
// assumes byte writes come from the serial port decoder
`timescale 1ns/1ps
module fecb_coef_reg #(
    parameter int          bytes = 2,
    parameter int          width = 12
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // byte write
    input  wire logic [bytes-1:0]     byte_write,
    input  wire logic [7:0]           write_data,
    // stored value
    output logic      [8*bytes-1:0]   stored,
    output logic      [8*bytes-1:0]   readback
);
    import fecb_pkg::*;
    genvar i;
    generate
        for (i = 0; i < bytes; i++) begin : g_byte
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset)
                    stored[8*i +: 8] <= fecb_reg_reset[7:0];
                else if (byte_write[i])
                    stored[8*i +: 8] <= write_data;
            end
        end
    endgenerate
    // coefficient msb always reads back as zero
    always_comb begin
        readback = stored;
        readback[width-1] = 1'b0;
    end
endmodule

/* hw/fecb_bank.sv */
// coefficient bank for the first five taps of the channel A equaliser
// assumes a serial control port front end giving byte reads and writes
`timescale 1ns/1ps
module fecb_bank (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // serial control port, byte access
    input  wire logic [14:0]          reg_addr,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    // filter configuration from the config register
    input  wire logic [1:0]           equalizer_mode_select,
    input  wire logic                 coefficient_share_enable,
    input  wire logic                 filter_merge_enable,
    input  wire logic                 serial_link_enable,
    // channel B own side and centre taps (from its own bank)
    input  wire logic [47:0]          chan_b_side_taps,
    input  wire logic [17:0]          chan_b_center_tap,
    // coefficients and run/merge flags to the filter datapath, linked-write flag
    output logic      [47:0]          chan_a_side_taps,
    output logic      [17:0]          chan_a_center_tap,
    output logic      [47:0]          chan_b_side_out,
    output logic      [17:0]          chan_b_center_out,
    output logic                      filter_run,
    output logic                      filter_merged,
    output logic                      write_while_linked
);
    import fecb_pkg::*;

    // ******************************************************
    // address decode
    // ******************************************************
    // base byte address of each side tap, tap order as the filter uses it
    localparam logic [14:0] side_base [fecb_side_taps] = '{fecb_tap0_addr,
        fecb_tap1_addr, fecb_tap2_addr, fecb_tap3_addr};
    logic [fecb_side_bytes-1:0] side_hit [fecb_side_taps];
    logic [15:0]                side_stored [fecb_side_taps];
    logic [15:0]                side_read [fecb_side_taps];
    wire  logic [14:0]          center_off = reg_addr - fecb_center_addr;
    wire  logic [2:0]           center_hit;
    wire  logic [23:0]          center_stored;
    wire  logic [23:0]          center_read;

    assign center_hit[0] = reg_write && center_off == 15'h0000;
    assign center_hit[1] = reg_write && center_off == 15'h0001;
    assign center_hit[2] = reg_write && center_off == 15'h0002;

    // ******************************************************
    // side tap registers
    // ******************************************************
    genvar t;
    generate
        for (t = 0; t < fecb_side_taps; t++) begin : g_side
            assign side_hit[t][0] = reg_write && reg_addr == side_base[t];
            assign side_hit[t][1] = reg_write &&
                reg_addr == side_base[t] + 15'h0001;
            fecb_coef_reg #(.bytes(fecb_side_bytes),
                            .width(fecb_side_width)) u_side (
                .core_clk   (core_clk),
                .reset      (reset),
                .byte_write (side_hit[t]),
                .write_data (reg_wdata),
                .stored     (side_stored[t]),
                .readback   (side_read[t])
            );
            // field is bits 11:0, signed; tap t feeds filter tap t
            assign chan_a_side_taps[12*t +: 12] =
                side_stored[t][fecb_side_width-1:0];
        end
    endgenerate

    // ******************************************************
    // centre tap register, 24 bits with 18-bit field
    // ******************************************************
    fecb_coef_reg #(.bytes(fecb_center_bytes),
                    .width(fecb_center_width)) u_center (
        .core_clk   (core_clk),
        .reset      (reset),
        .byte_write (center_hit),
        .write_data (reg_wdata),
        .stored     (center_stored),
        .readback   (center_read)
    );
    assign chan_a_center_tap =
        center_stored[fecb_center_width-1:0];

    // ******************************************************
    // filter control and sharing
    // ******************************************************
    // merged mode reuses the same words as leading taps, no remap
    assign filter_merged = filter_merge_enable;
    // reserved modes treated as bypass so the filter never half-runs
    assign filter_run = equalizer_mode_select == fecb_mode_run;
    assign chan_b_side_out = coefficient_share_enable ?
        chan_a_side_taps : chan_b_side_taps;
    assign chan_b_center_out = coefficient_share_enable ?
        chan_a_center_tap : chan_b_center_tap;
    // flags software ignoring the quiet-link requirement; write still lands
    assign write_while_linked = reg_write && serial_link_enable;

    // ******************************************************
    // readback
    // ******************************************************
    // read decode is kept apart from write decode so a read
    // never depends on the write strobe
    logic [fecb_side_bytes-1:0] side_rd_hit [fecb_side_taps];
    logic [7:0]                 side_rd_byte [fecb_side_taps];
    wire  logic [2:0]           center_rd_hit;
    wire  logic [7:0]           center_rd_byte;
    logic [7:0]                 next_rdata;

    generate
        for (t = 0; t < fecb_side_taps; t++) begin : g_side_rd
            assign side_rd_hit[t][0] = reg_addr == side_base[t];
            assign side_rd_hit[t][1] =
                reg_addr == side_base[t] + 15'h0001;
            // msb of the field already masked inside the register
            assign side_rd_byte[t] =
                side_rd_hit[t][0] ? side_read[t][7:0] :
                side_rd_hit[t][1] ? side_read[t][15:8] :
                8'h00;
        end
    endgenerate

    assign center_rd_hit[0] = center_off == 15'h0000;
    assign center_rd_hit[1] = center_off == 15'h0001;
    assign center_rd_hit[2] = center_off == 15'h0002;
    assign center_rd_byte =
        center_rd_hit[0] ? center_read[7:0] :
        center_rd_hit[1] ? center_read[15:8] :
        center_rd_hit[2] ? center_read[23:16] :
        8'h00;

    // unmapped addresses fall through to zero; at most one hit is set
    always_comb begin
        next_rdata = center_rd_byte;
        for (int i = 0; i < fecb_side_taps; i++) begin
            next_rdata = next_rdata | side_rd_byte[i];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= next_rdata;
    end
endmodule

/* tb/fecb_bank_props.sv */
// port checker for the channel A coefficient bank
// assumes it is bound onto every fecb_bank instance
`timescale 1ns/1ps
module fecb_bank_props (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // register port
    input wire logic [14:0] reg_addr,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // configuration levels
    input wire logic [1:0]  equalizer_mode_select,
    input wire logic        coefficient_share_enable,
    input wire logic        filter_merge_enable,
    input wire logic        serial_link_enable,
    // coefficients and flags
    input wire logic [47:0] chan_b_side_taps,
    input wire logic [17:0] chan_b_center_tap,
    input wire logic [47:0] chan_a_side_taps,
    input wire logic [17:0] chan_a_center_tap,
    input wire logic [47:0] chan_b_side_out,
    input wire logic [17:0] chan_b_center_out,
    input wire logic        filter_run,
    input wire logic        filter_merged,
    input wire logic        write_while_linked
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_wr(a); reg_write && reg_addr == a; endsequence
    sequence s_rd(a); reg_read && reg_addr == a; endsequence
    AST_RUN: assert property (
        filter_run == (equalizer_mode_select == 2'h2))
        else $error("filter run wrong");
    AST_MERGE: assert property (
        filter_merged == filter_merge_enable)
        else $error("merge flag wrong");
    AST_SHARE: assert property (
        chan_b_side_out == (coefficient_share_enable ?
        chan_a_side_taps : chan_b_side_taps))
        else $error("channel b taps wrong");
    AST_SHARE_C: assert property (
        chan_b_center_out == (coefficient_share_enable ?
        chan_a_center_tap : chan_b_center_tap))
        else $error("channel b centre wrong");
    AST_LINK: assert property (
        write_while_linked == (reg_write && serial_link_enable))
        else $error("linked write flag wrong");
    AST_TAP0: assert property (s_wr(15'h0418) |=>
        chan_a_side_taps[7:0] == $past(reg_wdata))
        else $error("tap0 not written");
    AST_TAP3: assert property (s_wr(15'h041f) |=>
        chan_a_side_taps[47:44] == $past(reg_wdata[3:0]))
        else $error("tap3 wrong");
    AST_CTR: assert property (s_wr(15'h0422) |=>
        chan_a_center_tap[17:16] == $past(reg_wdata[1:0]))
        else $error("centre wrong");
    AST_MSB: assert property (s_rd(15'h041b) |=> !reg_rdata[3])
        else $error("side msb read back set");
    AST_CMSB: assert property (s_rd(15'h0422) |=> !reg_rdata[1])
        else $error("centre msb read back set");
endmodule
bind fecb_bank fecb_bank_props PROPS (.*);

/* tb/tb.sv */
// self-checking bench for the channel A coefficient bank
// assumes the port checker is bound from its own file
`timescale 1ns/1ps
module tb;
    import fecb_pkg::*;
    logic        core_clk = 1'b0, reset = 1'b1, wl = 1'b0;
    logic        reg_write = 1'b0, reg_read = 1'b0;
    logic [14:0] reg_addr = 15'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic [1:0]  equalizer_mode_select = 2'h0;
    logic        coefficient_share_enable = 1'b0, filter_merge_enable = 1'b0;
    logic        serial_link_enable = 1'b0, filter_run, filter_merged;
    logic        write_while_linked;
    logic [47:0] chan_b_side_taps = 48'h123456789abc, chan_a_side_taps;
    logic [47:0] chan_b_side_out, exp_taps;
    logic [17:0] chan_b_center_tap = 18'h2aaaa, chan_a_center_tap;
    logic [17:0] chan_b_center_out;
    int          fails = 0, n_checks = 0;
    fecb_bank DUT (.*);
    initial forever #20 core_clk = ~core_clk;
    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(string n, logic [47:0] e, logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // idle edge after each write keeps strobes from toggling twice a step
    task automatic wr(logic [14:0] a, logic [7:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        #1 wl = write_while_linked;
        @(posedge core_clk);
        reg_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(logic [14:0] a, logic [7:0] e);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
        #1 chk("reg_rdata", {40'h0, e}, {40'h0, reg_rdata});
    endtask
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 11; i++)
            rd(15'h0418 + 15'(i), 8'h00);
        chk("side_taps", 48'h0, chan_a_side_taps);
        serial_link_enable <= 1'b1;
        for (int i = 0; i < 11; i++)
            wr(15'h0418 + 15'(i), 8'hff);
        chk("write_while_linked", 48'h1, {47'h0, wl});
        serial_link_enable <= 1'b0;
        chk("side_taps", {48{1'b1}}, chan_a_side_taps);
        chk("center_tap", 48'h3ffff, {30'h0, chan_a_center_tap});
        for (int i = 0; i < 11; i++)
            rd(15'h0418 + 15'(i), i == 10 ? 8'hfd :
               (i < 8 && i % 2 == 1) ? 8'hf7 : 8'hff);
        rd(15'h0417, 8'h00);
        rd(15'h0423, 8'h00);
        filter_merge_enable <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            wr(15'h0418 + 15'(2 * t), 8'(8'h10 + t));
            wr(15'h0419 + 15'(2 * t), 8'h00);
            exp_taps[12 * t +: 12] = 12'(12'h010 + t);
        end
        wr(15'h0420, 8'h01);
        wr(15'h0421, 8'h00);
        wr(15'h0422, 8'h02);
        chk("side_taps", exp_taps, chan_a_side_taps);
        chk("filter_merged", 48'h1, {47'h0, filter_merged});
        chk("center_tap", 48'h20001, {30'h0, chan_a_center_tap});
        rd(15'h0422, 8'h00);
        for (int m = 0; m < 4; m++) begin
            equalizer_mode_select <= 2'(m);
            step();
            chk("filter_run", {47'h0, m == 2}, {47'h0, filter_run});
        end
        for (int s = 0; s < 2; s++) begin
            coefficient_share_enable <= 1'(s);
            step();
            chk("b_side", s ? exp_taps : chan_b_side_taps,
                chan_b_side_out);
            chk("b_center", s ? 48'h20001 : 48'h2aaaa,
                {30'h0, chan_b_center_out});
        end
        summarize();
    end
endmodule
